// [core/cpu_phase_sequencer.sv]
// machine-phase sequencer of a small 16-bit stored-program computer
// assumes a synchronous memory: strobe sampled at an edge, read data
// valid the cycle after; panel pushbuttons arrive as one-cycle pulses
//
// Function
// - set-location copies switches to program counter and address reg, fetch next
// - deposit writes switches to addressed word, then bumps both address regs
// - phase-step runs exactly one machine phase then stops, registers held
// - fetch reads word at address reg into data reg as an instruction
// - in T6/T7 of fetch, data reg bits 0-9 go to address reg bits 0-9
// - current-page reference leaves upper address reg bits unchanged
// - instruction bit 10 zero clears address bits 10-15, one keeps them
// - direct memory-reference fetch ends in execute, counter and accumulator kept
// - fetched bit 15 set selects indirect phase instead of execute
// - indirect phase reads address word into address reg as new reference
// - after indirect read, bit 15 zero gives execute, one stays indirect
// - execute, except a store, reads the word at address reg into data reg as data
// - load-accumulator copies data reg into accumulator
// - add-to-accumulator adds operand to accumulator, sum kept there
// - store-accumulator writes accumulator via data reg; both hold value
// - every instruction ends: counter plus one into both, fetch phase set
// - stop instruction halts after advancing counter and address, fetch pending
// - word 143777 decodes as indirect current-page add via location 3777
// - examine reads word at address reg into data reg
`timescale 1ns/1ps
module cpu_phase_sequencer (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire seq_pkg::word_t switch_in,
    input wire logic set_location_in,
    input wire logic deposit_in,
    input wire logic examine_in,
    input wire logic run_in,
    input wire logic phase_step_in,
    input wire logic stop_in,
    input wire seq_pkg::word_t mem_rdata_in,
    output seq_pkg::word_t mem_addr_out,
    output seq_pkg::word_t mem_wdata_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output seq_pkg::word_t pc_out,
    output seq_pkg::word_t mar_out,
    output seq_pkg::word_t mdr_out,
    output seq_pkg::word_t acc_out,
    output logic [1:0] phase_out,
    output logic halted_out
);
    import seq_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    op_state_t op_state_reg;
    phase_t phase_reg;
    word_t pc_reg;
    word_t mar_reg;
    word_t mdr_reg;
    word_t ir_reg;
    word_t acc_reg;
    logic run_reg;
    logic halted_reg;
    logic rd_reg;
    logic wr_reg;
    logic [2:0] interval;

    // instruction class; used at the end of fetch and during execute
    function automatic instr_t decode(input word_t w);
        instr_t k;
        k = I_MEMREF;
        if (w == STOP_WORD) begin
            k = I_STOP;
        end else if (w[GROUP_MSB:GROUP_LSB] == GROUP_NONMEM) begin
            k = I_NONMEM;
        end else if (w[OPC_MSB:OPC_LSB] == OPC_LOAD) begin
            k = I_LOAD;
        end else if (w[OPC_MSB:OPC_LSB] == OPC_ADD) begin
            k = I_ADD;
        end else if (w[OPC_MSB:OPC_LSB] == OPC_STORE) begin
            k = I_STORE;
        end
        return k;
    endfunction

    // ------------------------------------------------------------
    // interval timing
    // ------------------------------------------------------------
    interval_counter u_intervals (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .busy_in(op_state_reg != ST_IDLE),
        .interval_out(interval)
    );

    // ------------------------------------------------------------
    // decode of panel requests and phase events
    // ------------------------------------------------------------
    // panel requests are honoured only while halted; priority is
    // set-location, deposit, examine, run, phase-step
    logic idle;
    logic go_set;
    logic go_dep;
    logic go_exam;
    logic go_run;
    logic go_step;
    logic cyc;
    logic at_end;
    logic in_fetch;
    logic in_ind;
    logic in_exec;
    instr_t kind;
    logic memref;
    logic halting;
    logic finish;
    logic reads;
    logic stores;

    assign idle = (op_state_reg == ST_IDLE);
    assign go_set = idle && set_location_in;
    assign go_dep = idle && !set_location_in && deposit_in;
    assign go_exam = idle && !set_location_in && !deposit_in && examine_in;
    assign go_run = idle && !set_location_in && !deposit_in && !examine_in && run_in;
    assign go_step = idle && !set_location_in && !deposit_in && !examine_in
                     && !run_in && phase_step_in;
    assign cyc = (op_state_reg == ST_CYCLE);
    assign at_end = (interval == T_END);
    assign in_fetch = cyc && (phase_reg == PH_FETCH);
    assign in_ind = cyc && (phase_reg == PH_INDIRECT);
    assign in_exec = cyc && (phase_reg == PH_EXECUTE);
    assign kind = decode(ir_reg);
    assign memref = (kind != I_STOP) && (kind != I_NONMEM);
    assign halting = in_fetch && at_end && (kind == I_STOP);
    // last action of an instruction: end of execute, or end of a fetch
    // that has no operand to chase
    assign finish = at_end && (in_exec || (in_fetch && !memref));
    assign stores = in_exec && (kind == I_STORE);
    // every phase but a store-execute spends its memory cycle on a read
    assign reads = (cyc && !stores) || (op_state_reg == ST_EXAMINE);

    // ------------------------------------------------------------
    // operating state, run latch, halt indicator
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            op_state_reg <= ST_IDLE;
            halted_reg <= 1'b1;
        end else if (go_dep) begin
            op_state_reg <= ST_DEPOSIT;
            halted_reg <= 1'b0;
        end else if (go_exam) begin
            op_state_reg <= ST_EXAMINE;
            halted_reg <= 1'b0;
        end else if (go_run || go_step) begin
            op_state_reg <= ST_CYCLE;
            halted_reg <= 1'b0;
        end else if (!idle && at_end) begin
            // a step stops after one phase; a stop or stop_in ends a run
            if (cyc && run_reg && !stop_in && !halting) begin
                op_state_reg <= ST_CYCLE;
            end else begin
                op_state_reg <= ST_IDLE;
                halted_reg <= 1'b1;
            end
        end
    end

    // run latch: set by run, dropped by step, stop_in or the stop word
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            run_reg <= 1'b0;
        end else if (go_run) begin
            run_reg <= 1'b1;
        end else if (go_step || stop_in || halting) begin
            run_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // machine phase
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_reg <= PH_FETCH;
        end else if (go_set) begin
            phase_reg <= PH_FETCH;
        end else if (cyc && at_end) begin
            if (finish) begin
                phase_reg <= PH_FETCH;
            end else if (in_fetch) begin
                phase_reg <= ir_reg[INDIRECT_BIT] ? PH_INDIRECT : PH_EXECUTE;
            end else if (in_ind) begin
                phase_reg <= mdr_reg[INDIRECT_BIT] ? PH_INDIRECT : PH_EXECUTE;
            end
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    // untouched by indirect phases and by a memory-reference fetch so the table of a step
    // shows the instruction's own location until it completes
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pc_reg <= WORD_RESET;
        end else if (go_set) begin
            pc_reg <= switch_in;
        end else if (op_state_reg == ST_DEPOSIT && at_end) begin
            pc_reg <= pc_reg + WORD_ONE;
        end else if (cyc && finish) begin
            pc_reg <= pc_reg + WORD_ONE;
        end
    end

    // ------------------------------------------------------------
    // memory address register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mar_reg <= WORD_RESET;
        end else if (go_set) begin
            mar_reg <= switch_in;
        end else if (op_state_reg == ST_DEPOSIT && at_end) begin
            mar_reg <= mar_reg + WORD_ONE;
        end else if (cyc && finish) begin
            mar_reg <= pc_reg + WORD_ONE;
        end else if (in_fetch && interval == T_REF && memref) begin
            // reference field in, page bits kept or cleared by bit 10
            mar_reg[REF_MSB:0] <= ir_reg[REF_MSB:0];
            if (!ir_reg[PAGE_SEL_BIT]) begin
                mar_reg[WORD_W-1:PAGE_LSB] <= PAGE_ZERO;
            end
        end else if (in_ind && interval == T_REF) begin
            mar_reg <= mdr_reg;
        end
    end

    // ------------------------------------------------------------
    // memory data register and instruction latch
    // ------------------------------------------------------------
    // the instruction is latched separately because execute reuses
    // the data register for the operand
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mdr_reg <= WORD_RESET;
        end else if (go_dep) begin
            mdr_reg <= switch_in;
        end else if (stores && interval == T_LOAD_WR) begin
            mdr_reg <= acc_reg;
        end else if (reads && interval == T_CAP) begin
            mdr_reg <= mem_rdata_in;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ir_reg <= WORD_RESET;
        end else if (in_fetch && interval == T_CAP) begin
            ir_reg <= mem_rdata_in;
        end
    end

    // ------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc_reg <= WORD_RESET;
        end else if (in_exec && interval == T_ALU) begin
            if (kind == I_LOAD) begin
                acc_reg <= mdr_reg;
            end else if (kind == I_ADD) begin
                acc_reg <= acc_reg + mdr_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // memory strobes: one read or one write per phase
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
        end else begin
            rd_reg <= reads && (interval == T_RD);
            wr_reg <= (stores || op_state_reg == ST_DEPOSIT)
                      && (interval == T_WR);
        end
    end

    assign mem_addr_out = mar_reg;
    assign mem_wdata_out = mdr_reg;
    assign mem_rd_out = rd_reg;
    assign mem_wr_out = wr_reg;
    assign pc_out = pc_reg;
    assign mar_out = mar_reg;
    assign mdr_out = mdr_reg;
    assign acc_out = acc_reg;
    assign phase_out = phase_reg;
    assign halted_out = halted_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence dep_start_s;
        go_dep;
    endsequence

    sequence dep_write_s;
        ##4 (mem_wr_out && mem_wdata_out == $past(switch_in, 4));
    endsequence

    sequence step_start_s;
        go_step;
    endsequence

    sequence one_phase_s;
        (!halted_out) [*8] ##1 halted_out;
    endsequence

    set_location_a: assert property (go_set |=>
        pc_out == $past(switch_in) && mar_out == $past(switch_in)
        && phase_reg == PH_FETCH)
        else $error("set location did not load both address registers");

    deposit_write_a: assert property (dep_start_s |-> dep_write_s)
        else $error("deposit did not write the switch value");

    deposit_bump_a: assert property (go_dep |-> ##9
        pc_out == $past(pc_out, 9) + WORD_ONE)
        else $error("deposit did not advance the counter");

    single_phase_a: assert property (step_start_s |=> one_phase_s)
        else $error("phase step did not stop after eight intervals");

    fetch_read_a: assert property (in_fetch && interval == T_CAP |=>
        ir_reg == $past(mem_rdata_in) && mdr_out == $past(mem_rdata_in))
        else $error("fetch did not capture the instruction");

    page_bits_a: assert property (in_fetch && memref && interval == T_REF |=>
        mar_out[REF_MSB:0] == $past(ir_reg[REF_MSB:0])
        && mar_out[WORD_W-1:PAGE_LSB] == ($past(ir_reg[PAGE_SEL_BIT])
            ? $past(mar_out[WORD_W-1:PAGE_LSB]) : PAGE_ZERO))
        else $error("reference bits or page bits wrong after fetch");

    indirect_pick_a: assert property (in_fetch && memref && at_end |=>
        phase_reg == ($past(ir_reg[INDIRECT_BIT]) ? PH_INDIRECT : PH_EXECUTE))
        else $error("wrong phase after fetch");

    chain_level_a: assert property (in_ind && at_end |=>
        phase_reg == ($past(mdr_reg[INDIRECT_BIT]) ? PH_INDIRECT : PH_EXECUTE)
        && mar_out == $past(mdr_reg))
        else $error("wrong phase or address after indirect read");

    add_sum_a: assert property (in_exec && kind == I_ADD && interval == T_ALU |=>
        acc_out == $past(acc_out) + $past(mdr_out))
        else $error("accumulator does not hold the sum");

    store_data_a: assert property (mem_wr_out && cyc |->
        mem_wdata_out == acc_out && stores)
        else $error("store wrote something other than the accumulator");

    instr_end_a: assert property (cyc && finish |=>
        pc_out == $past(pc_out) + WORD_ONE && mar_out == pc_out
        && phase_reg == PH_FETCH)
        else $error("instruction end did not advance to next location");

endmodule

// [core/seq_pkg.sv]
// constants, types and timing of the machine-phase sequencer
// assumes one 100 MHz clock; panel and memory signals are synchronous to it
package seq_pkg;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    typedef logic [WORD_W-1:0] word_t;
    localparam int REF_MSB = 9;        // memory reference field 0..9
    localparam int PAGE_SEL_BIT = 10;  // 0 = page zero, 1 = current page
    localparam int PAGE_LSB = 10;      // page bits 10..15 of the address
    localparam int INDIRECT_BIT = 15;
    localparam int OPC_MSB = 14;       // operation field 11..14
    localparam int OPC_LSB = 11;
    localparam int GROUP_MSB = 14;     // 000 here marks a non-memory group
    localparam int GROUP_LSB = 12;
    localparam logic [5:0] PAGE_ZERO = 6'h00;
    localparam word_t WORD_ONE = 16'h0001;
    localparam word_t WORD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // operation codes and the stop word
    // ------------------------------------------------------------
    localparam logic [3:0] OPC_LOAD = 4'hC;
    localparam logic [3:0] OPC_ADD = 4'h8;
    localparam logic [3:0] OPC_STORE = 4'hE;
    localparam logic [2:0] GROUP_NONMEM = 3'h0;
    localparam word_t STOP_WORD = 16'h8400;

    // ------------------------------------------------------------
    // timing intervals within one machine phase
    // ------------------------------------------------------------
    localparam logic [2:0] T_FIRST = 3'h0;
    localparam logic [2:0] T_RD = 3'h0;      // read strobe raised at end of T0
    localparam logic [2:0] T_LOAD_WR = 3'h1; // write data staged in data reg
    localparam logic [2:0] T_CAP = 3'h2;     // read data captured
    localparam logic [2:0] T_WR = 3'h2;      // write strobe raised at end of T2
    localparam logic [2:0] T_ALU = 3'h4;     // accumulator update
    localparam logic [2:0] T_REF = 3'h6;     // reference bits to address reg
    localparam logic [2:0] T_END = 3'h7;     // phase boundary

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_FETCH = 2'b00,
        PH_INDIRECT = 2'b01,
        PH_EXECUTE = 2'b10
    } phase_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CYCLE = 2'b01,
        ST_DEPOSIT = 2'b10,
        ST_EXAMINE = 2'b11
    } op_state_t;

    typedef enum logic [2:0] {
        I_LOAD = 3'b000,
        I_ADD = 3'b001,
        I_STORE = 3'b010,
        I_STOP = 3'b011,
        I_MEMREF = 3'b100,
        I_NONMEM = 3'b101
    } instr_t;

endpackage

// [core/interval_counter.sv]
// timing-interval counter: steps T0..T7 while a phase is running
// assumes busy_in is a registered level from the sequencer
`timescale 1ns/1ps
module interval_counter (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic busy_in,
    output logic [2:0] interval_out
);
    import seq_pkg::*;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // wraps from T7 to T0 so phases run back to back; parks at T0 when idle
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            interval_out <= T_FIRST;
        end else if (busy_in) begin
            interval_out <= interval_out + 3'h1;
        end else begin
            interval_out <= T_FIRST;
        end
    end

endmodule

// [sim/core_memory_model.sv]
// behavioural read/write memory standing at the far side of the sequencer
// assumes strobes sampled at a rising edge, read data valid the next cycle
`timescale 1ns/1ps
module core_memory_model (
    input wire logic mclk_in,
    input wire seq_pkg::word_t mem_addr_in,
    input wire seq_pkg::word_t mem_wdata_in,
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    output seq_pkg::word_t mem_rdata_out
);
    import seq_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    word_t mem_reg [0:65535];
    word_t rdata_reg = 16'h0000;

    // one word per strobe; data stays valid for a single cycle only, after
    // that it toggles so a late capture in the design cannot pass by luck
    always_ff @(posedge mclk_in) begin
        if (mem_wr_in) begin
            mem_reg[mem_addr_in] <= mem_wdata_in;
        end
        if (mem_rd_in) begin
            rdata_reg <= mem_reg[mem_addr_in];
        end else begin
            rdata_reg <= ~rdata_reg;
        end
    end

    assign mem_rdata_out = rdata_reg; // registered, one-cycle latency
endmodule

// [sim/cpu_phase_sequencer_bench.sv]
// self-checking bench: panel load, single-phase walk, run, random references
// assumes the memory model beside the design and the package constants
`timescale 1ns/1ps
module cpu_phase_sequencer_bench;
    import seq_pkg::*;

    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    word_t switch_in = 16'h0000;
    logic set_location_in = 1'b0;
    logic deposit_in = 1'b0;
    logic examine_in = 1'b0;
    logic run_in = 1'b0;
    logic phase_step_in = 1'b0;
    logic stop_in = 1'b0;
    word_t mem_rdata, mem_addr, mem_wdata, pc, mar, mdr, acc;
    logic mem_rd, mem_wr, halted;
    logic [1:0] phase;
    int num_errors = 0;
    int n_checks = 0;
    int n_strobe = 0;
    localparam word_t PROG [6] = '{16'h6601, 16'hC7FF, 16'h7600, 16'h8400, 16'h8400, 16'h0005};
    // each row: data reg, counter, address reg, accumulator, phase
    localparam logic [65:0] TAB [8] = '{
        {16'h6601, 16'h05FC, 16'h0601, 16'h0000, PH_EXECUTE},
        {16'h0005, 16'h05FD, 16'h05FD, 16'h0005, PH_FETCH},
        {16'hC7FF, 16'h05FD, 16'h07FF, 16'h0005, PH_INDIRECT},
        {16'h0601, 16'h05FD, 16'h0601, 16'h0005, PH_EXECUTE},
        {16'h0005, 16'h05FE, 16'h05FE, 16'h000A, PH_FETCH},
        {16'h7600, 16'h05FE, 16'h0600, 16'h000A, PH_EXECUTE},
        {16'h000A, 16'h05FF, 16'h05FF, 16'h000A, PH_FETCH},
        {16'h8400, 16'h0600, 16'h0600, 16'h000A, PH_FETCH}};

    always #5 mclk_in = ~mclk_in;

    // memory strobes seen so far; a phase with two memory cycles or none
    // would otherwise slip past the register checks
    always @(posedge mclk_in) begin
        if (mem_rd === 1'b1 || mem_wr === 1'b1) n_strobe++;
    end

    cpu_phase_sequencer i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .switch_in(switch_in), .set_location_in(set_location_in), .deposit_in(deposit_in),
        .examine_in(examine_in), .run_in(run_in), .phase_step_in(phase_step_in),
        .stop_in(stop_in), .mem_rdata_in(mem_rdata), .mem_addr_out(mem_addr),
        .mem_wdata_out(mem_wdata), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr), .pc_out(pc),
        .mar_out(mar), .mdr_out(mdr), .acc_out(acc), .phase_out(phase), .halted_out(halted));

    core_memory_model i_mem (.mclk_in(mclk_in), .mem_addr_in(mem_addr),
        .mem_wdata_in(mem_wdata), .mem_rd_in(mem_rd), .mem_wr_in(mem_wr),
        .mem_rdata_out(mem_rdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task end_sim;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk_w(input word_t g, input word_t e, input string m);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task chk_p(input logic [1:0] g, input logic [1:0] e);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: phase got %b exp %b", $time, g, e);
        end
    endtask

    task regs(input word_t t, input word_t p, input word_t m, input word_t a,
              input logic [1:0] ph);
        chk_w(mdr, t, "data reg");
        chk_w(pc, p, "counter");
        chk_w(mar, m, "address reg");
        chk_w(acc, a, "accumulator");
        chk_w(mem_addr, m, "memory address");
        chk_w(mem_wdata, t, "write data");
        chk_p(phase, ph);
    endtask

    // one pulse on a panel button: 0 set, 1 deposit, 2 examine, 3 run, 4 step;
    // then a bounded wait until the machine is halted again
    task press(input int k, input word_t sw);
        int n;
        @(posedge mclk_in);
        switch_in <= sw;
        set_location_in <= (k == 0);
        deposit_in <= (k == 1);
        examine_in <= (k == 2);
        run_in <= (k == 3);
        phase_step_in <= (k == 4);
        @(posedge mclk_in);
        {set_location_in, deposit_in, examine_in, run_in, phase_step_in} <= 5'h00;
        for (n = 0; n < 300; n++) begin
            #1;
            if (halted === 1'b1) break;
            @(posedge mclk_in);
        end
        if (n == 300) chk_w(16'h0000, 16'h0001, "panel wait");
    endtask

    function word_t mref(input logic ind, input logic [3:0] opc, input logic cur,
                         input logic [9:0] r);
        return {ind, opc, cur, r};
    endfunction

    function word_t pz(input logic [9:0] r);
        return {PAGE_ZERO, r};
    endfunction

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge mclk_in);
        num_errors++;
        end_sim();
    end

    initial begin
        word_t ia, d, a_exp;
        logic [9:0] r;
        int i;
        int s0;
        void'($urandom(32'haa5d));
        repeat (3) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        press(0, 16'h05FC);
        chk_w(pc, 16'h05FC, "set counter");
        chk_w(mar, 16'h05FC, "set address");
        chk_p(phase, PH_FETCH);
        for (i = 0; i < 6; i++) begin
            press(1, PROG[i]);
            chk_w(pc, 16'h05FD + 16'(i), "deposit counter");
            chk_w(mar, 16'h05FD + 16'(i), "deposit address");
        end
        press(0, 16'h07FF);
        press(1, 16'h0601);
        press(0, 16'h05FC);
        press(2, 16'h0000);
        chk_w(mdr, 16'h6601, "examine");
        // single-phase walk, row by row
        for (i = 0; i < 8; i++) begin
            s0 = n_strobe;
            press(4, 16'h0000);
            regs(TAB[i][65:50], TAB[i][49:34], TAB[i][33:18], TAB[i][17:2],
                 TAB[i][1:0]);
            chk_w(16'(n_strobe - s0), 16'h0001, "strobes in one phase");
        end
        // free run over a scrambled answer word
        press(0, 16'h0600);
        press(1, 16'($urandom));
        press(0, 16'h05FC);
        press(3, 16'h0000);
        regs(16'h8400, 16'h0600, 16'h0600, 16'h000A, PH_FETCH);
        press(2, 16'h0000);
        chk_w(mdr, 16'h000A, "stored answer");
        // page-zero direct load, then an indirect add stepped up to its second indirect phase
        a_exp = 16'h000A;
        for (i = 0; i < 4; i++) begin
            ia = {6'($urandom_range(63, 1)), 10'($urandom_range(1000, 0))};
            r = 10'($urandom);
            d = 16'($urandom) & 16'h7FFF;
            press(0, ia);
            press(1, mref(1'b0, OPC_LOAD, 1'b0, r));
            press(1, mref(1'b1, OPC_ADD, 1'b0, r ^ 10'h001));
            press(0, pz(r));
            press(1, d);
            press(0, pz(r ^ 10'h001));
            press(1, 16'h8000 | 16'($urandom));
            press(0, ia);
            press(4, 16'h0000);
            regs(mref(1'b0, OPC_LOAD, 1'b0, r), ia, pz(r), a_exp, PH_EXECUTE);
            press(4, 16'h0000);
            a_exp = d;
            regs(d, ia + 16'h0001, ia + 16'h0001, d, PH_FETCH);
            press(4, 16'h0000);
            regs(mref(1'b1, OPC_ADD, 1'b0, r ^ 10'h001), ia + 16'h0001, pz(r ^ 10'h001), d,
                 PH_INDIRECT);
            press(4, 16'h0000);
            chk_p(phase, PH_INDIRECT);
        end
        // a run with stop held ends after one phase; a no-op word only advances
        press(0, ia);
        @(posedge mclk_in);
        stop_in <= 1'b1;
        press(3, 16'h0000);
        regs(mref(1'b0, OPC_LOAD, 1'b0, r), ia, pz(r), a_exp, PH_EXECUTE);
        @(posedge mclk_in);
        stop_in <= 1'b0;
        press(0, ia);
        press(1, 16'h0000);
        press(0, ia);
        press(4, 16'h0000);
        regs(16'h0000, ia + 16'h0001, ia + 16'h0001, a_exp, PH_FETCH);
        end_sim();
    end
endmodule
